// ==== inc/drrb_pkg.sv ====
// Constants of the dual regulator register bank
package drrb_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_DEVICE_REVISION_ID = 8'h00;
	localparam logic [7:0] ADDR_OTP_VER = 8'h01;
	localparam logic [7:0] ADDR_REG0_CTRL = 8'h02;
	localparam logic [7:0] ADDR_OUT1_DLY = 8'h10;
	localparam logic [7:0] ADDR_OUT2_DLY = 8'h11;
	localparam logic [7:0] ADDR_GENERAL_OUTPUT_CONTROL = 8'h12;
	localparam logic [7:0] ADDR_CONFIG = 8'h13;
	localparam logic [7:0] ADDR_CLK_SYNC = 8'h14;
	localparam logic [7:0] ADDR_PG_CTRL1 = 8'h15;
	localparam logic [7:0] ADDR_PG_CTRL2 = 8'h16;
	localparam logic [7:0] ADDR_POWER_GOOD_FAULT_STATUS = 8'h17;
	localparam logic [7:0] ADDR_SW_RESET = 8'h18;
	localparam logic [7:0] ADDR_INT_TOP1 = 8'h19;
	localparam logic [7:0] ADDR_INT_TOP2 = 8'h1A;
	localparam logic [7:0] ADDR_INT_REG = 8'h1B;
	localparam logic [7:0] ADDR_TOP_STAT = 8'h1D;
	localparam logic [7:0] ADDR_REG_STAT = 8'h1E;
	localparam logic [7:0] ADDR_MASK_TOP1 = 8'h20;
	localparam logic [7:0] ADDR_MASK_TOP2 = 8'h21;
	localparam logic [7:0] ADDR_MASK_REG = 8'h22;
	localparam logic [7:0] ADDR_LOAD_SEL = 8'h24;
	localparam logic [7:0] ADDR_LOAD_HI = 8'h25;
	localparam logic [7:0] ADDR_LOAD_LO = 8'h26;
	localparam int REG_SLOTS = 64;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_FORCE_PWM = 3;
	localparam int CTRL_DISCHARGE = 2;
	localparam int CTRL_EN_SOURCE = 1;
	localparam int CTRL_SW_ENABLE = 0;
	localparam int PART_ID_MSB = 7;
	localparam int PART_ID_LSB = 6;
	// ****************************************
	// Reset values, writable-bit masks and readable-bit masks
	// ****************************************
	localparam logic [7:0] RST_REG0_CTRL = 8'h04;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] MASK_NONE = 8'h00;
	localparam logic [7:0] MASK_ALL = 8'hFF;
	localparam logic [7:0] MASK_REG0_CTRL = 8'h0F;
	localparam logic [7:0] MASK_GENERAL_OUTPUT_CONTROL = 8'h77;
	localparam logic [7:0] MASK_CONFIG = 8'h7F;
	localparam logic [7:0] MASK_CLK_SYNC = 8'h5F;
	localparam logic [7:0] MASK_PG_CTRL1 = 8'hD3;
	localparam logic [7:0] MASK_PG_CTRL2 = 8'h07;
	localparam logic [7:0] MASK_BIT0 = 8'h01;
	localparam logic [7:0] MASK_INT_TOP1 = 8'hBF;
	localparam logic [7:0] MASK_INT_REG = 8'h77;
	localparam logic [7:0] MASK_MASK_TOP1 = 8'h95;
	localparam logic [7:0] MASK_MASK_REG = 8'hDD;
	localparam logic [7:0] MASK_PART_ID = 8'hC0;
	localparam logic [7:0] MASK_POWER_GOOD_FAULT_STATUS = 8'h03;
	localparam logic [7:0] MASK_TOP_STAT = 8'h9E;
	localparam logic [7:0] MASK_REG_STAT = 8'hDD;
	localparam logic [7:0] MASK_LOAD_HI = 8'h03;
endpackage

// ==== hdl/drrb_register_bank.sv ====
// Register bank of the dual regulator controller, byte side of the serial slave
// Operation
// - Control bit 3 chooses automatic PFM/PWM at 0 and forced PWM at 1.
// - Control bit 2 enables the output discharge while the regulator is off, reset value 1.
// - Control bit 1 at 0 lets the software bit alone enable, at 1 the pin must also be high.
// - Control bit 0 is the software enable that turns the regulator off at 0 and on at 1.
// - Address one reads a read-only eight-bit memory version code.
// - Bits without a fixed reset value are loaded from the one-time memory after power-up.
// - The index advances by one after each written data byte, reads do not advance it.
`timescale 1ns/10ps
module drrb_register_bank
	import drrb_pkg::*;
#(
	parameter logic [5:0] REV_LOW_BITS = 6'h15 // Arbitrary value
)
(
	input wire logic clk_sys, // 40 MHz system clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic busStart, // Pulse: addressed transfer begins
	input wire logic busWrValid, // Pulse: written byte present
	input wire logic [7:0] busWrData, // Written byte
	input wire logic busRdReq, // Pulse: master wants a byte
	output logic [7:0] busRdData, // Byte read back
	output logic busRdValid, // Pulse: busRdData valid
	input wire logic otpWrValid, // Pulse: memory-read state loads a byte
	input wire logic [7:0] otpWrAddr, // Register loaded
	input wire logic [7:0] otpWrData, // Value loaded
	input wire logic enablePin, // External enable pin, asynchronous
	input wire logic [7:0] topEvents1, // Event pulses, top flags 1
	input wire logic [7:0] topEvents2, // Event pulses, top flags 2
	input wire logic [7:0] regEvents, // Event pulses, regulator flags
	input wire logic [7:0] pgFaultIn, // Power-good fault status
	input wire logic [7:0] topStatusIn, // Top status
	input wire logic [7:0] regStatusIn, // Regulator status
	input wire logic [7:0] loadHighIn, // Load current high byte
	input wire logic [7:0] loadLowIn, // Load current low byte
	output logic reg0Enable, // Regulator 0 runs
	output logic reg0ForcePwm, // Regulator 0 forced PWM
	output logic reg0DischargeOn // Regulator 0 discharge path active
);

	// ****************************************
	// Address decoding
	// ****************************************
	function automatic logic [7:0] writeMask(input logic [7:0] a);
		logic [7:0] m;
		m = MASK_NONE;
		unique case (a)
			ADDR_REG0_CTRL: m = MASK_REG0_CTRL;
			ADDR_OUT1_DLY, ADDR_OUT2_DLY: m = MASK_ALL;
			ADDR_GENERAL_OUTPUT_CONTROL: m = MASK_GENERAL_OUTPUT_CONTROL;
			ADDR_CONFIG: m = MASK_CONFIG;
			ADDR_CLK_SYNC: m = MASK_CLK_SYNC;
			ADDR_PG_CTRL1: m = MASK_PG_CTRL1;
			ADDR_PG_CTRL2: m = MASK_PG_CTRL2;
			ADDR_SW_RESET, ADDR_INT_TOP2, ADDR_MASK_TOP2, ADDR_LOAD_SEL: m = MASK_BIT0;
			ADDR_INT_TOP1: m = MASK_INT_TOP1;
			ADDR_INT_REG: m = MASK_INT_REG;
			ADDR_MASK_TOP1: m = MASK_MASK_TOP1;
			ADDR_MASK_REG: m = MASK_MASK_REG;
			default: m = MASK_NONE;
		endcase
		return m;
	endfunction

	function automatic logic isFlag(input logic [7:0] a);
		return (a == ADDR_INT_TOP1) || (a == ADDR_INT_TOP2) || (a == ADDR_INT_REG);
	endfunction

	// The memory-read state may also fill the identity registers
	function automatic logic [7:0] otpMask(input logic [7:0] a);
		logic [7:0] m;
		m = writeMask(a);
		if (a == ADDR_DEVICE_REVISION_ID)
			m = MASK_PART_ID;
		else if (a == ADDR_OTP_VER)
			m = MASK_ALL;
		return m;
	endfunction

	function automatic logic [7:0] resetValue(input int a);
		return (a == int'(ADDR_REG0_CTRL)) ? RST_REG0_CTRL : RST_ZERO;
	endfunction

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] regMem [REG_SLOTS];
	logic [7:0] next_regMem [REG_SLOTS];
	logic [7:0] regIndex;
	logic [7:0] next_regIndex;
	logic expectIndex;
	logic pinMeta;
	logic pinSync;

	wire logic hostDataWr = busWrValid && !expectIndex;
	wire logic [7:0] hostMask = writeMask(regIndex);
	wire logic [7:0] otpBits = otpMask(otpWrAddr);
	wire logic [7:0] ctrl = regMem[ADDR_REG0_CTRL[5:0]];

	always_comb
	begin
		for (int i = 0; i < REG_SLOTS; i++)
		begin
			next_regMem[i] = regMem[i];
			if (isFlag(8'(i)))
			begin
				// Write one to clear; a new event in the same cycle still sets
				if (hostDataWr && regIndex == 8'(i))
					next_regMem[i] = regMem[i] & ~(busWrData & hostMask);
				if (8'(i) == ADDR_INT_TOP1)
					next_regMem[i] = next_regMem[i] | (topEvents1 & MASK_INT_TOP1);
				else if (8'(i) == ADDR_INT_TOP2)
					next_regMem[i] = next_regMem[i] | (topEvents2 & MASK_BIT0);
				else
					next_regMem[i] = next_regMem[i] | (regEvents & MASK_INT_REG);
			end
			else if (otpWrValid && otpWrAddr == 8'(i))
				next_regMem[i] = (regMem[i] & ~otpBits) | (otpWrData & otpBits);
			else if (hostDataWr && regIndex == 8'(i))
				next_regMem[i] = (regMem[i] & ~hostMask) | (busWrData & hostMask);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		for (int i = 0; i < REG_SLOTS; i++)
		begin
			if (!rst_n)
				regMem[i] <= resetValue(i);
			else
				regMem[i] <= next_regMem[i];
		end
	end

	// ****************************************
	// Index handling
	// ****************************************
	always_comb
	begin
		next_regIndex = regIndex;
		if (busWrValid && expectIndex)
			next_regIndex = busWrData;
		else if (hostDataWr)
			next_regIndex = 8'(regIndex + 8'h01);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			regIndex <= RST_ZERO;
			expectIndex <= 1'b0;
		end
		else
		begin
			regIndex <= next_regIndex;
			if (busStart)
				expectIndex <= 1'b1;
			else if (busWrValid)
				expectIndex <= 1'b0;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	logic [7:0] readMux;
	always_comb
	begin
		readMux = RST_ZERO;
		unique case (regIndex)
			ADDR_DEVICE_REVISION_ID: readMux = {regMem[ADDR_DEVICE_REVISION_ID[5:0]][PART_ID_MSB:PART_ID_LSB],
				REV_LOW_BITS};
			ADDR_OTP_VER: readMux = regMem[ADDR_OTP_VER[5:0]];
			ADDR_POWER_GOOD_FAULT_STATUS: readMux = pgFaultIn & MASK_POWER_GOOD_FAULT_STATUS;
			ADDR_TOP_STAT: readMux = topStatusIn & MASK_TOP_STAT;
			ADDR_REG_STAT: readMux = regStatusIn & MASK_REG_STAT;
			ADDR_LOAD_HI: readMux = loadHighIn & MASK_LOAD_HI;
			ADDR_LOAD_LO: readMux = loadLowIn;
			default: readMux = regMem[regIndex[5:0]] & writeMask(regIndex);
		endcase
	end

	// Reads leave the index alone, so repeated reads return one register
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			busRdData <= RST_ZERO;
			busRdValid <= 1'b0;
		end
		else
		begin
			busRdValid <= busRdReq;
			if (busRdReq)
				busRdData <= readMux;
		end
	end

	// ****************************************
	// Regulator 0 control
	// ****************************************
	// Pin is asynchronous: two stages before use
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
		end
		else
		begin
			pinMeta <= enablePin;
			pinSync <= pinMeta;
		end
	end

	wire logic enableGate = !ctrl[CTRL_EN_SOURCE] || pinSync;
	assign reg0Enable = ctrl[CTRL_SW_ENABLE] && enableGate;
	assign reg0ForcePwm = ctrl[CTRL_FORCE_PWM];
	assign reg0DischargeOn = ctrl[CTRL_DISCHARGE] && !reg0Enable;

	// ****************************************
	// Assertions
	// ****************************************
	sequence ctrlHostWrite;
		hostDataWr && regIndex == ADDR_REG0_CTRL && !otpWrValid;
	endsequence

	sequence dataByteWrite;
		hostDataWr && !busStart;
	endsequence

	a_force_pwm_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrlHostWrite |=> reg0ForcePwm == $past(busWrData[CTRL_FORCE_PWM]))
		else $error("force PWM bit not taken from write");

	a_discharge_reset: assert property (@(posedge clk_sys)
		!rst_n |=> ctrl[CTRL_DISCHARGE] && ctrl[7:4] == 4'h0)
		else $error("discharge bit not set by reset");

	a_enable_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrl[CTRL_SW_ENABLE] && ctrl[CTRL_EN_SOURCE] && !pinSync |-> !reg0Enable)
		else $error("pin gating ignored");

	a_sw_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrlHostWrite ##0 (busWrData[CTRL_EN_SOURCE:CTRL_SW_ENABLE] == 2'b01)
		|=> reg0Enable && !reg0DischargeOn)
		else $error("software enable not effective");

	a_part_id_ro: assert property (@(posedge clk_sys) disable iff (!rst_n)
		hostDataWr && regIndex == ADDR_DEVICE_REVISION_ID && !otpWrValid
		|=> $stable(regMem[ADDR_DEVICE_REVISION_ID[5:0]]))
		else $error("host changed part code");

	a_version_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		busRdReq && regIndex == ADDR_OTP_VER
		|=> busRdValid && busRdData == $past(regMem[ADDR_OTP_VER[5:0]]))
		else $error("version read wrong");

	a_otp_load_ctrl: assert property (@(posedge clk_sys) disable iff (!rst_n)
		otpWrValid && otpWrAddr == ADDR_REG0_CTRL
		|=> ctrl == ($past(otpWrData) & MASK_REG0_CTRL))
		else $error("memory load of control failed");

	a_index_advance: assert property (@(posedge clk_sys) disable iff (!rst_n)
		dataByteWrite |=> regIndex == 8'($past(regIndex) + 8'h01))
		else $error("index did not advance");

	a_read_no_advance: assert property (@(posedge clk_sys) disable iff (!rst_n)
		busRdReq && !busWrValid |=> $stable(regIndex) && busRdValid)
		else $error("read moved the index");

	a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		busRdReq && writeMask(regIndex) == MASK_NONE && regIndex > ADDR_LOAD_LO
		|=> busRdData == RST_ZERO)
		else $error("unlisted address read nonzero");

endmodule

// ==== tb/drrb_host_model.sv ====
// Byte-level host master of the regulator register bank
`timescale 1ns/10ps
module drrb_host_model
(
	input wire logic clk_sys, // System clock
	output logic busStart, // Transfer start pulse
	output logic busWrValid, // Written byte strobe
	output logic [7:0] busWrData, // Written byte
	output logic busRdReq, // Read request pulse
	input wire logic [7:0] busRdData, // Byte read back
	input wire logic busRdValid // Read byte strobe
);
	initial
	begin
		busStart = 1'b0;
		busWrValid = 1'b0;
		busWrData = 8'h00;
		busRdReq = 1'b0;
	end
	// Index byte, then one data byte, or two when n > 1, on back-to-back cycles
	task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input int n);
		@(posedge clk_sys);
		busStart <= 1'b1;
		@(posedge clk_sys);
		busStart <= 1'b0;
		busWrValid <= 1'b1;
		busWrData <= a;
		@(posedge clk_sys);
		busWrData <= d0;
		if (n > 1)
		begin
			@(posedge clk_sys);
			busWrData <= d1;
		end
		@(posedge clk_sys);
		busWrValid <= 1'b0;
	endtask
	// Reads never advance the index, so each read sets it afresh
	task automatic rd(input logic [7:0] a, output logic [7:0] q [2], output bit ok);
		int k;
		ok = 1'b1;
		@(posedge clk_sys);
		busStart <= 1'b1;
		@(posedge clk_sys);
		busStart <= 1'b0;
		busWrValid <= 1'b1;
		busWrData <= a;
		@(posedge clk_sys);
		busWrValid <= 1'b0;
		for (int r = 0; r < 2; r++)
		begin
			busRdReq <= 1'b1;
			@(posedge clk_sys);
			busRdReq <= 1'b0;
			k = 0;
			do
			begin
				@(posedge clk_sys);
				k++;
			end
			while (busRdValid !== 1'b1 && k < 4);
			ok &= (busRdValid === 1'b1);
			q[r] = busRdData;
		end
	endtask
endmodule

// ==== tb/test_dual_regulator_register_bank.sv ====
// Self-checking bench of the regulator register bank
`timescale 1ns/10ps
module test_dual_regulator_register_bank;
	import drrb_pkg::*;
	localparam logic [5:0] REV = 6'h15; // Arbitrary value
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic busStart, busWrValid, busRdReq, busRdValid;
	logic [7:0] busWrData, busRdData;
	logic otpWrValid = 1'b0;
	logic [7:0] otpWrAddr = 8'h00;
	logic [7:0] otpWrData = 8'h00;
	logic enablePin = 1'b0;
	logic [7:0] topEvents1 = 8'h00, topEvents2 = 8'h00, regEvents = 8'h00;
	logic [7:0] pgFaultIn = 8'h00, topStatusIn = 8'h00, regStatusIn = 8'h00;
	logic [7:0] loadHighIn = 8'h00, loadLowIn = 8'h00;
	logic reg0Enable, reg0ForcePwm, reg0DischargeOn, en;
	int mismatches = 0;
	int samples_checked = 0;
	logic [7:0] q [2];
	bit ok;
	logic [7:0] sa [5] = '{ADDR_POWER_GOOD_FAULT_STATUS, ADDR_TOP_STAT, ADDR_REG_STAT, ADDR_LOAD_LO, ADDR_LOAD_HI};
	logic [7:0] se [5] = '{8'h03, 8'h9E, 8'hDD, 8'hFF, 8'h03};

	always #12.5 clk_sys = ~clk_sys;

	drrb_register_bank #(.REV_LOW_BITS(REV)) dut (.clk_sys, .rst_n, .busStart, .busWrValid,
		.busWrData, .busRdReq, .busRdData, .busRdValid, .otpWrValid, .otpWrAddr, .otpWrData,
		.enablePin, .topEvents1, .topEvents2, .regEvents, .pgFaultIn, .topStatusIn,
		.regStatusIn, .loadHighIn, .loadLowIn, .reg0Enable, .reg0ForcePwm, .reg0DischargeOn);
	drrb_host_model host (.clk_sys, .busStart, .busWrValid, .busWrData, .busRdReq,
		.busRdData, .busRdValid);

	// ****
	// Tasks
	// ****
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, q, ok);
		if (!ok)
		begin
			mismatches++;
			report_and_stop();
		end
		chk("read", q[0], exp);
		chk("reread", q[1], exp);
	endtask
	task automatic otp(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		otpWrValid <= 1'b1;
		otpWrAddr <= a;
		otpWrData <= d;
		@(posedge clk_sys);
		otpWrValid <= 1'b0;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		report_and_stop();
	end

	// ****
	// Scenarios
	// ****
	initial
	begin
		repeat (6) @(posedge clk_sys);
		chk("discharge", {7'h00, reg0DischargeOn}, 8'h01);
		rst_n <= 1'b1;
		rdchk(ADDR_REG0_CTRL, RST_REG0_CTRL);
		rdchk(ADDR_DEVICE_REVISION_ID, {2'b00, REV});
		otp(ADDR_DEVICE_REVISION_ID, 8'hFF);
		otp(ADDR_OTP_VER, 8'hA5);
		otp(ADDR_REG0_CTRL, 8'h0A);
		rdchk(ADDR_DEVICE_REVISION_ID, {2'b11, REV});
		rdchk(ADDR_OTP_VER, 8'hA5);
		rdchk(ADDR_REG0_CTRL, 8'h0A);
		host.wr(ADDR_OTP_VER, 8'h3C, 8'h00, 1);
		host.wr(ADDR_DEVICE_REVISION_ID, 8'h00, 8'h00, 1);
		host.wr(8'h03, 8'h55, 8'h00, 1);
		rdchk(ADDR_DEVICE_REVISION_ID, {2'b11, REV});
		rdchk(ADDR_OTP_VER, 8'hA5);
		rdchk(ADDR_REG0_CTRL, 8'h0A);
		host.wr(ADDR_OUT1_DLY, 8'h12, 8'h34, 2);
		rdchk(ADDR_OUT1_DLY, 8'h12);
		rdchk(ADDR_OUT2_DLY, 8'h34);
		host.wr(ADDR_REG0_CTRL, 8'hFF, 8'h77, 2);
		rdchk(ADDR_REG0_CTRL, 8'h0F);
		host.wr(8'h30, 8'hFF, 8'h00, 1);
		rdchk(8'h30, 8'h00);
		pgFaultIn <= 8'hFF;
		topStatusIn <= 8'hFF;
		regStatusIn <= 8'hFF;
		loadHighIn <= 8'hFF;
		loadLowIn <= 8'hFF;
		for (int i = 0; i < 5; i++)
		begin
			host.wr(sa[i], 8'h00, 8'h00, 1);
			rdchk(sa[i], se[i]);
		end
		topEvents1 <= 8'hFF;
		topEvents2 <= 8'hFF;
		regEvents <= 8'hFF;
		@(posedge clk_sys);
		topEvents1 <= 8'h00;
		topEvents2 <= 8'h00;
		regEvents <= 8'h00;
		rdchk(ADDR_INT_TOP1, 8'hBF);
		rdchk(ADDR_INT_TOP2, 8'h01);
		host.wr(ADDR_INT_REG, 8'h01, 8'h00, 1);
		rdchk(ADDR_INT_REG, 8'h76);
		// An event landing on the clearing byte must keep its flag set
		fork
			host.wr(ADDR_INT_REG, 8'h02, 8'h00, 1);
			begin
				repeat (3) @(posedge clk_sys);
				regEvents <= 8'h02;
				@(posedge clk_sys);
				regEvents <= 8'h00;
			end
		join
		rdchk(ADDR_INT_REG, 8'h76);
		// Every control code against both pin levels
		for (int v = 0; v < 32; v++)
		begin
			host.wr(ADDR_REG0_CTRL, {4'h0, v[3:0]}, 8'h00, 1);
			enablePin <= v[4];
			repeat (4) @(posedge clk_sys);
			en = v[0] & (!v[1] | v[4]);
			chk("force_pwm", {7'h00, reg0ForcePwm}, {7'h00, v[3]});
			chk("enable", {7'h00, reg0Enable}, {7'h00, en});
			chk("discharge", {7'h00, reg0DischargeOn}, {7'h00, v[2] & !en});
		end
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdchk(ADDR_REG0_CTRL, RST_REG0_CTRL);
		report_and_stop();
	end
endmodule
